/* File: hdl/led_ctrl_pkg.sv */
package led_ctrl_pkg;
	// bus address and direction bit
	localparam logic [6:0] SLAVE_ADDR = 7'h1b;
	localparam logic WRITE_BIT = 1'b0;
	// reset values of the three active data registers
	localparam logic [7:0] REG_RST = 8'h00;
	// option byte field positions
	localparam int FORCE_DOUBLE_BIT = 7;
	localparam int FORCE_MID_BIT = 6;
	localparam int TEST_HIGH_BIT = 5;
	localparam int TEST_LOW_BIT = 4;
	localparam int CAM_OVERRIDE_BIT = 3;
	localparam int SHORT_DELAY_BIT = 2;
	localparam int AUX_MSB_BIT = 1;
	localparam int AUX_LSB_BIT = 0;
	// camera code halves
	localparam int CAM_HIGH_MSB = 7;
	localparam int CAM_HIGH_LSB = 4;
	localparam int CAM_LOW_MSB = 3;
	localparam int CAM_LOW_LSB = 0;
	// receiver slot figures, counted in link clock edges
	localparam logic [3:0] BITS_AT_START_SEEN = 4'h3;
	localparam logic [3:0] ADDR_LAST_BIT = 4'h8;
	localparam logic [3:0] ACK_BIT = 4'h9;
	localparam logic [1:0] LAST_DATA_BYTE = 2'h3;
	// dropout qualification delays
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned LONG_DELAY_MS = 150;
	localparam int unsigned SHORT_DELAY_MS = 2;
	localparam int CYC_W = 25;
	localparam int unsigned LONG_DELAY_CYC = LONG_DELAY_MS * 1000 * CLK_MHZ;
	localparam int unsigned SHORT_DELAY_CYC = SHORT_DELAY_MS * 1000 * CLK_MHZ;
	// pump mode codes on the output port
	localparam logic [1:0] PUMP_CODE_1X = 2'h0;
	localparam logic [1:0] PUMP_CODE_1P5X = 2'h1;
	localparam logic [1:0] PUMP_CODE_2X = 2'h2;
	typedef enum logic [1:0] {MODE_1X, MODE_1P5X, MODE_2X} mode_type;
endpackage : led_ctrl_pkg

/* File: hdl/stage_if.sv */
`timescale 1ns/1ps
interface stage_if;
	logic [7:0] byte0;
	logic [7:0] byte1;
	logic [7:0] byte2;
	logic done_tog;
	logic start_tog;
	modport rx
	(
		output byte0,
		output byte1,
		output byte2,
		output done_tog,
		input start_tog
	);
	modport core
	(
		input byte0,
		input byte1,
		input byte2,
		input done_tog,
		output start_tog
	);
endinterface : stage_if

/* File: hdl/dropout_timer.sv */
`timescale 1ns/1ps
module dropout_timer
#(
	parameter int CW = led_ctrl_pkg::CYC_W
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [CW-1:0] len,
	output logic expire
);
	logic [CW-1:0] cnt_r;

	// any gap in dropout starts the wait over
	always_ff @(posedge core_clk)
	begin
		if (!rst_b || !run)
			cnt_r <= '0;
		else if (cnt_r >= len - 1'b1)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			expire <= 1'b0;
		else
			expire <= run && (cnt_r >= len - 1'b1);
	end

	a_timer_restart: assert property (@(posedge core_clk) disable iff (!rst_b)
		!run |=> cnt_r == '0 && !expire)
		else $error("dropout timer kept counting without dropout");
endmodule : dropout_timer

/* File: hdl/i2c_rx.sv */
`timescale 1ns/1ps
module i2c_rx
(
	input wire logic scl_clk,
	input wire logic rst_b,
	input wire logic sda_in,
	output logic sda_oe,
	stage_if.rx stg
);
	logic rs1_r, rs2_r, st1_r, st2_r, seen_r, act_r, ack_r;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [1:0] byte_r;
	logic [7:0] sh_r, b0_r, b1_r;
	logic new_start;

	// reset and start event both cross in on the link clock
	always_ff @(posedge scl_clk)
	begin
		rs1_r <= rst_b;
		rs2_r <= rs1_r;
		st1_r <= stg.start_tog;
		st2_r <= st1_r;
	end

	// start toggle lands two edges late; the bit count makes up for it
	assign new_start = st2_r != seen_r;
	assign cnt_nxt = new_start ? led_ctrl_pkg::BITS_AT_START_SEEN :
		(cnt_r == led_ctrl_pkg::ACK_BIT) ? 4'h1 : cnt_r + 4'h1;

	always_ff @(posedge scl_clk)
	begin
		if (!rs2_r)
		begin
			seen_r <= 1'b0;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			byte_r <= 2'h0;
			act_r <= 1'b0;
			ack_r <= 1'b0;
			b0_r <= 8'h00;
			b1_r <= 8'h00;
			stg.byte0 <= 8'h00;
			stg.byte1 <= 8'h00;
			stg.byte2 <= 8'h00;
			stg.done_tog <= 1'b0;
		end
		else
		begin
			seen_r <= st2_r;
			cnt_r <= cnt_nxt;
			sh_r <= {sh_r[6:0], sda_in};
			ack_r <= 1'b0;
			if (new_start)
			begin
				byte_r <= 2'h0;
				act_r <= 1'b0;
			end
			else if (cnt_nxt == led_ctrl_pkg::ADDR_LAST_BIT)
				ack_r <= (byte_r == 2'h0) ? ({sh_r[6:0], sda_in} ==
					{led_ctrl_pkg::SLAVE_ADDR, led_ctrl_pkg::WRITE_BIT}) : act_r;
			else if (cnt_nxt == led_ctrl_pkg::ACK_BIT)
			begin
				if (byte_r == 2'h0)
				begin
					act_r <= ack_r;
					byte_r <= 2'h1;
				end
				else if (act_r)
				begin
					// bytes latch on their acknowledge; only a full set is published
					if (byte_r == 2'h1)
						b0_r <= sh_r;
					if (byte_r == 2'h2)
						b1_r <= sh_r;
					if (byte_r == led_ctrl_pkg::LAST_DATA_BYTE)
					begin
						stg.byte0 <= b0_r;
						stg.byte1 <= b1_r;
						stg.byte2 <= sh_r;
						stg.done_tog <= ~stg.done_tog;
						act_r <= 1'b0;
					end
					else
						byte_r <= byte_r + 2'h1;
				end
			end
		end
	end

	// pull low from the falling edge after bit 8 to the one after the ack clock
	always_ff @(negedge scl_clk)
	begin
		if (!rs2_r)
			sda_oe <= 1'b0;
		else
			sda_oe <= ack_r && (cnt_r == led_ctrl_pkg::ADDR_LAST_BIT);
	end
endmodule : i2c_rx

/* File: hdl/led_driver_i2c_mode_control.sv */
`timescale 1ns/1ps
module led_driver_i2c_mode_control
#(
	parameter logic [led_ctrl_pkg::CYC_W-1:0] LONG_CYC =
		led_ctrl_pkg::CYC_W'(led_ctrl_pkg::LONG_DELAY_CYC),
	parameter logic [led_ctrl_pkg::CYC_W-1:0] SHORT_CYC =
		led_ctrl_pkg::CYC_W'(led_ctrl_pkg::SHORT_DELAY_CYC)
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic scl_clk,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic cam_level_select_pin,
	input wire logic main_dropout,
	input wire logic cam_dropout,
	input wire logic reference_resistor_input,
	input wire logic thermal_fault,
	output logic [7:0] main_dac,
	output logic main_en,
	output logic [3:0] cam_dac,
	output logic cam_en,
	output logic [1:0] aux_dac,
	output logic aux_en,
	output logic aux_gpo_oe,
	output logic [1:0] pump_mode,
	output logic pump_en,
	output logic shutdown
);
	stage_if stg ();

	logic [6:0] in_s1_r, in_s2_r;
	logic scl_q, sda_q, cam_q, main_drop_q, cam_drop_q, reference_resistor_input_q, therm_q;
	logic scl_d_r, sda_d_r, cam_d_r;
	logic start_tog_r, dn_s1_r, dn_s2_r, dn_d_r, pend_r, load_r;
	logic [7:0] hold_main_r, hold_cam_r, hold_opt_r;
	logic [7:0] main_brightness_r, camera_high_low_codes_r, aux_and_options_r;
	led_ctrl_pkg::mode_type mode_r;
	logic bus_start, bus_stop, new_set, load_cond, cam_fall, mode_reset;
	logic force_double_boost, force_mid_boost, forced, cam_override, short_dropout_delay;
	logic [1:0] aux_code;
	logic [3:0] cam_code;
	logic fault, all_zero, drop_seen, tmr_run, tmr_expire;
	logic [led_ctrl_pkg::CYC_W-1:0] tmr_len;

	// link-side receiver; SDA sampled on the link clock's own edges
	i2c_rx rx_u
	(
		.scl_clk(scl_clk),
		.rst_b(rst_b),
		.sda_in(sda_in),
		.sda_oe(sda_oe),
		.stg(stg.rx)
	);

	// pins cross by two flops; the second stage is a plain copy of the first and filters no glitches
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			in_s1_r <= 7'h03;
			in_s2_r <= 7'h03;
		end
		else
		begin
			in_s1_r <= {therm_in(thermal_fault), reference_resistor_input, cam_dropout,
				main_dropout, cam_level_select_pin, sda_in, scl_clk};
			in_s2_r <= in_s1_r;
		end
	end

	function automatic logic therm_in(input logic v);
		therm_in = v;
	endfunction : therm_in

	assign {therm_q, reference_resistor_input_q, cam_drop_q, main_drop_q, cam_q, sda_q, scl_q} = in_s2_r;

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			cam_d_r <= 1'b0;
		end
		else
		begin
			scl_d_r <= scl_q;
			sda_d_r <= sda_q;
			cam_d_r <= cam_q;
		end
	end

	assign bus_start = scl_q && scl_d_r && sda_d_r && !sda_q;
	assign bus_stop = scl_q && scl_d_r && !sda_d_r && sda_q;
	assign cam_fall = cam_d_r && !cam_q;

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			start_tog_r <= 1'b0;
		else if (bus_start)
			start_tog_r <= ~start_tog_r;
	end

	assign stg.start_tog = start_tog_r;

	// completed-set toggle crosses back; staging is quiet long before a stop
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			dn_s1_r <= 1'b0;
			dn_s2_r <= 1'b0;
			dn_d_r <= 1'b0;
		end
		else
		begin
			dn_s1_r <= stg.done_tog;
			dn_s2_r <= dn_s1_r;
			dn_d_r <= dn_s2_r;
		end
	end

	assign new_set = dn_s2_r != dn_d_r;
	assign load_cond = bus_stop && pend_r;

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			hold_main_r <= led_ctrl_pkg::REG_RST;
			hold_cam_r <= led_ctrl_pkg::REG_RST;
			hold_opt_r <= led_ctrl_pkg::REG_RST;
		end
		else if (new_set)
		begin
			hold_main_r <= stg.byte0;
			hold_cam_r <= stg.byte1;
			hold_opt_r <= stg.byte2;
		end
	end

	// a set arriving with the stop stays pending for the next stop
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			pend_r <= 1'b0;
		else if (new_set)
			pend_r <= 1'b1;
		else if (load_cond)
			pend_r <= 1'b0;
	end

	// one load pulse moves all three bytes at once
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			main_brightness_r <= led_ctrl_pkg::REG_RST;
			camera_high_low_codes_r <= led_ctrl_pkg::REG_RST;
			aux_and_options_r <= led_ctrl_pkg::REG_RST;
			load_r <= 1'b0;
		end
		else
		begin
			load_r <= load_cond;
			if (load_cond)
			begin
				main_brightness_r <= hold_main_r;
				camera_high_low_codes_r <= hold_cam_r;
				aux_and_options_r <= hold_opt_r;
			end
		end
	end

	// test bits are left unused; the host keeps them zero
	assign force_double_boost = aux_and_options_r[led_ctrl_pkg::FORCE_DOUBLE_BIT];
	assign force_mid_boost = aux_and_options_r[led_ctrl_pkg::FORCE_MID_BIT];
	assign cam_override = aux_and_options_r[led_ctrl_pkg::CAM_OVERRIDE_BIT];
	assign short_dropout_delay = aux_and_options_r[led_ctrl_pkg::SHORT_DELAY_BIT];
	assign aux_code = {aux_and_options_r[led_ctrl_pkg::AUX_MSB_BIT],
		aux_and_options_r[led_ctrl_pkg::AUX_LSB_BIT]};
	assign forced = force_double_boost || force_mid_boost;

	// override picks the high code and masks the pin
	assign cam_code = (cam_override || cam_q) ?
		camera_high_low_codes_r[led_ctrl_pkg::CAM_HIGH_MSB:led_ctrl_pkg::CAM_HIGH_LSB] :
		camera_high_low_codes_r[led_ctrl_pkg::CAM_LOW_MSB:led_ctrl_pkg::CAM_LOW_LSB];

	assign fault = reference_resistor_input_q || therm_q;
	assign all_zero = (main_brightness_r == 8'h00) && (cam_code == 4'h0) &&
		(camera_high_low_codes_r == 8'h00) && (aux_code == 2'h0);

	// aux has no dropout sense, so only main and camera count
	assign drop_seen = (main_drop_q && main_brightness_r != 8'h00) ||
		(cam_drop_q && cam_code != 4'h0);
	assign mode_reset = load_r || cam_fall;
	assign tmr_run = drop_seen && !forced && !fault && !all_zero && !mode_reset &&
		mode_r != led_ctrl_pkg::MODE_2X;
	// pin only shortens the wait while it is honoured
	assign tmr_len = (short_dropout_delay || (cam_q && !cam_override)) ? SHORT_CYC : LONG_CYC;

	dropout_timer #(.CW(led_ctrl_pkg::CYC_W)) tmr_u
	(
		.core_clk(core_clk),
		.rst_b(rst_b),
		.run(tmr_run),
		.len(tmr_len),
		.expire(tmr_expire)
	);

	// mode steps; reset events beat the force bits for one cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			mode_r <= led_ctrl_pkg::MODE_1X;
		else if (mode_reset)
			mode_r <= led_ctrl_pkg::MODE_1X;
		else if (force_double_boost)
			mode_r <= led_ctrl_pkg::MODE_2X;
		else if (force_mid_boost)
			mode_r <= led_ctrl_pkg::MODE_1P5X;
		else if (tmr_expire)
		begin
			unique case (mode_r)
				led_ctrl_pkg::MODE_1X: mode_r <= led_ctrl_pkg::MODE_1P5X;
				led_ctrl_pkg::MODE_1P5X: mode_r <= led_ctrl_pkg::MODE_2X;
				led_ctrl_pkg::MODE_2X: mode_r <= led_ctrl_pkg::MODE_2X;
				default: mode_r <= led_ctrl_pkg::MODE_1X;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			main_dac <= 8'h00;
			main_en <= 1'b0;
			cam_dac <= 4'h0;
			cam_en <= 1'b0;
			aux_dac <= 2'h0;
			aux_en <= 1'b0;
			aux_gpo_oe <= 1'b0;
			pump_mode <= led_ctrl_pkg::PUMP_CODE_1X;
			pump_en <= 1'b0;
			shutdown <= 1'b1;
			sda_out <= 1'b0;
		end
		else
		begin
			main_dac <= main_brightness_r;
			main_en <= main_brightness_r != 8'h00 && !fault;
			cam_dac <= cam_code;
			cam_en <= cam_code != 4'h0 && !fault;
			aux_dac <= aux_code;
			aux_en <= aux_code != 2'h0 && !fault;
			// open drain pulls low while the code is nonzero and no fault is present
			aux_gpo_oe <= aux_code != 2'h0 && !fault;
			unique case (mode_r)
				led_ctrl_pkg::MODE_1X: pump_mode <= led_ctrl_pkg::PUMP_CODE_1X;
				led_ctrl_pkg::MODE_1P5X: pump_mode <= led_ctrl_pkg::PUMP_CODE_1P5X;
				led_ctrl_pkg::MODE_2X: pump_mode <= led_ctrl_pkg::PUMP_CODE_2X;
				default: pump_mode <= led_ctrl_pkg::PUMP_CODE_1X;
			endcase
			pump_en <= !all_zero && !fault;
			shutdown <= all_zero;
			sda_out <= 1'b0;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_load_all_bytes: assert property (load_r |-> main_brightness_r == $past(hold_main_r) &&
		camera_high_low_codes_r == $past(hold_cam_r) &&
		aux_and_options_r == $past(hold_opt_r))
		else $error("active registers not loaded together");
	// load_r is one register behind the stop it answers
	a_load_needs_stop: assert property ($rose(load_r) |-> $past(bus_stop) && $past(pend_r))
		else $error("load without stop and complete set");
	a_mode_reset_1x: assert property (mode_reset |=> mode_r == led_ctrl_pkg::MODE_1X)
		else $error("mode not returned to 1x");
	a_force_double: assert property (!mode_reset && force_double_boost
		|=> mode_r == led_ctrl_pkg::MODE_2X)
		else $error("force double did not hold 2x");
	a_force_mid: assert property (!mode_reset && force_mid_boost && !force_double_boost
		|=> mode_r == led_ctrl_pkg::MODE_1P5X)
		else $error("force mid did not hold 1.5x");
	a_step_needs_delay: assert property (mode_r == led_ctrl_pkg::MODE_1X && !forced && !tmr_expire
		|=> mode_r == led_ctrl_pkg::MODE_1X)
		else $error("mode stepped without qualified dropout");
	a_forced_no_timer: assert property (forced |-> !tmr_run)
		else $error("auto switching active while forced");
	a_cam_low_code: assert property (!cam_override && !cam_q ##1 !cam_override
		|-> cam_dac == $past(camera_high_low_codes_r[3:0]))
		else $error("camera not following low code");
	a_cam_override: assert property (cam_override ##1 cam_override
		|-> cam_dac == $past(camera_high_low_codes_r[7:4]))
		else $error("override did not select high code");
	a_fault_disables: assert property (fault |=> !pump_en && !main_en && !cam_en && !aux_en)
		else $error("outputs active during fault");
	a_zero_shutdown: assert property (all_zero |=> shutdown && !pump_en)
		else $error("no shutdown with all codes zero");
	a_short_delay: assert property (short_dropout_delay |-> tmr_len == SHORT_CYC)
		else $error("short delay option ignored");
	a_aux_no_dropout: assert property (main_brightness_r == 8'h00 && cam_code == 4'h0
		|-> !drop_seen)
		else $error("aux contributed to dropout");

	c_load_seen: cover property (load_r);
	c_reach_double: cover property (mode_r == led_ctrl_pkg::MODE_1P5X ##1 mode_r == led_ctrl_pkg::MODE_2X);
	c_cam_fall_reset: cover property (cam_fall && mode_r != led_ctrl_pkg::MODE_1X);
	c_fault_seen: cover property ($rose(fault));
endmodule : led_driver_i2c_mode_control

/* File: tb/host_i2c_model.sv */
`timescale 1ns/1ps
// bus master in the host's place; sda is open drain with a pull-up
// scl pulses are short, the low phase is stretched so sda never moves
// while the core's synchronised copy of scl may still look high
module host_i2c_model
(
	output logic scl,
	output logic sda_low,
	input wire logic sda_wire
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task idle_clocks(input int n);
		repeat (n)
		begin
			#24 scl = 1'b0;
			#24 scl = 1'b1;
		end
	endtask : idle_clocks

	task start;
		sda_low = 1'b0;
		scl = 1'b1;
		#48 sda_low = 1'b1;
		#48 scl = 1'b0;
	endtask : start

	task stop;
		#24 sda_low = 1'b1;
		#24 scl = 1'b1;
		#48 sda_low = 1'b0;
		#48;
	endtask : stop

	task bit_slot(input logic b, output logic seen);
		#24 sda_low = ~b;
		#24 scl = 1'b1;
		#5 seen = sda_wire;
		#1 scl = 1'b0;
	endtask : bit_slot

	// eight bits msb first, then sda released for the ack clock
	task put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_slot(b[i], s);
		bit_slot(1'b1, s);
		ack = ~s;
	endtask : put_byte
endmodule : host_i2c_model

/* File: tb/test_led_driver_i2c_mode_control.sv */
`timescale 1ns/1ps
module test_led_driver_i2c_mode_control;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cam_level_select_pin = 1'b0;
	logic main_dropout = 1'b0;
	logic cam_dropout = 1'b0;
	logic reference_resistor_input = 1'b0;
	logic thermal_fault = 1'b0;
	logic scl;
	logic sda_low;
	logic sda_wire;
	logic sda_out;
	logic sda_oe;
	logic [7:0] main_dac;
	logic main_en;
	logic [3:0] cam_dac;
	logic cam_en;
	logic [1:0] aux_dac;
	logic aux_en;
	logic aux_gpo_oe;
	logic [1:0] pump_mode;
	logic pump_en;
	logic shutdown;
	logic [3:0] acks;
	int errors = 0;
	int checked = 0;

	always #4 core_clk = ~core_clk;
	assign sda_wire = !(sda_low || (sda_oe && !sda_out));

	host_i2c_model host
	(
		.scl(scl),
		.sda_low(sda_low),
		.sda_wire(sda_wire)
	);

	// short delays keep the run brief: long 40, short 10 cycles
	led_driver_i2c_mode_control #(.LONG_CYC(25'h28), .SHORT_CYC(25'h0a)) dut
	(
		.core_clk(core_clk),
		.rst_b(rst_b),
		.scl_clk(scl),
		.sda_in(sda_wire),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.cam_level_select_pin(cam_level_select_pin),
		.main_dropout(main_dropout),
		.cam_dropout(cam_dropout),
		.reference_resistor_input(reference_resistor_input),
		.thermal_fault(thermal_fault),
		.main_dac(main_dac),
		.main_en(main_en),
		.cam_dac(cam_dac),
		.cam_en(cam_en),
		.aux_dac(aux_dac),
		.aux_en(aux_en),
		.aux_gpo_oe(aux_gpo_oe),
		.pump_mode(pump_mode),
		.pump_en(pump_en),
		.shutdown(shutdown)
	);

	task check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	task check_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit

	task results;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	task cycles(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cycles

	// address byte, then n of the three data bytes, then stop
	task frame(input logic [7:0] a, input logic [23:0] d, input int n);
		acks = 4'h0;
		host.start();
		host.put_byte(a, acks[3]);
		for (int i = 0; i < n && acks[3] === 1'b1; i++)
			host.put_byte(d[23-8*i -: 8], acks[2-i]);
		host.stop();
		cycles(10);
	endtask : frame

	task wait_pump(input logic [1:0] exp, input int max);
		for (int i = 0; i < max && pump_mode !== exp; i++)
			@(posedge core_clk);
		// stay on the edge so the next stimulus still lands on a rising edge
		check_val("pump_mode", {6'h00, exp}, {6'h00, pump_mode});
	endtask : wait_pump

	task drop(input logic m, input logic c);
		main_dropout <= m;
		cam_dropout <= c;
	endtask : drop

	initial
	begin
		#300us;
		errors++;
		results();
	end

	initial
	begin
		// receiver reset needs scl edges while rst_b is low
		host.idle_clocks(4);
		cycles(4);
		rst_b <= 1'b1;
		cycles(6);
		check_bit("shutdown", 1'b1, shutdown);
		check_val("main_dac", 8'h00, main_dac);
		check_bit("sda_oe", 1'b0, sda_oe);
		check_bit("sda_out", 1'b0, sda_out);
		$display("test reset done");

		frame(8'h36, 24'ha5_9c_01, 3);
		check_val("acks", 8'h0f, {4'h0, acks});
		check_val("main_dac", 8'ha5, main_dac);
		check_val("cam_dac low", 8'h0c, {4'h0, cam_dac});
		check_val("aux_dac", 8'h01, {6'h00, aux_dac});
		check_bit("aux_gpo_oe", 1'b1, aux_gpo_oe);
		check_bit("aux_en", 1'b1, aux_en);
		check_bit("cam_en", 1'b1, cam_en);
		check_bit("shutdown", 1'b0, shutdown);
		cam_level_select_pin <= 1'b1;
		cycles(6);
		check_val("cam_dac high", 8'h09, {4'h0, cam_dac});
		cam_level_select_pin <= 1'b0;
		$display("test write done");

		frame(8'h37, 24'h0, 3);
		check_val("acks read", 8'h00, {4'h0, acks});
		frame(8'h38, 24'h0, 3);
		check_val("acks other", 8'h00, {4'h0, acks});
		frame(8'h36, 24'h11_22_00, 1);
		check_val("acks part", 8'h0c, {4'h0, acks});
		check_val("main_dac kept", 8'ha5, main_dac);
		$display("test refusal done");

		frame(8'h36, 24'h80_3c_08, 3);
		check_val("cam_dac over", 8'h03, {4'h0, cam_dac});
		frame(8'h36, 24'h80_3c_00, 3);
		drop(1'b1, 1'b0);
		cycles(30);
		check_val("pump early", 8'h00, {6'h00, pump_mode});
		wait_pump(2'h1, 30);
		wait_pump(2'h2, 60);
		drop(1'b0, 1'b0);
		frame(8'h36, 24'h80_3c_00, 3);
		check_val("pump write", 8'h00, {6'h00, pump_mode});
		drop(1'b1, 1'b0);
		cycles(30);
		drop(1'b0, 1'b0);
		cycles(3);
		drop(1'b1, 1'b0);
		cycles(30);
		check_val("pump restart", 8'h00, {6'h00, pump_mode});
		drop(1'b0, 1'b0);
		$display("test auto mode done");

		frame(8'h36, 24'h80_3c_04, 3);
		drop(1'b1, 1'b0);
		wait_pump(2'h1, 25);
		drop(1'b0, 1'b0);
		frame(8'h36, 24'h80_3c_00, 3);
		cam_level_select_pin <= 1'b1;
		drop(1'b0, 1'b1);
		wait_pump(2'h1, 25);
		cam_level_select_pin <= 1'b0;
		cycles(6);
		check_val("pump pin fall", 8'h00, {6'h00, pump_mode});
		drop(1'b0, 1'b0);
		$display("test short delay done");

		frame(8'h36, 24'h80_3c_c0, 3);
		wait_pump(2'h2, 8);
		frame(8'h36, 24'h80_3c_40, 3);
		wait_pump(2'h1, 8);
		drop(1'b1, 1'b1);
		cycles(70);
		check_val("pump forced", 8'h01, {6'h00, pump_mode});
		drop(1'b0, 1'b0);
		$display("test forced mode done");

		for (int f = 0; f < 2; f++)
		begin
			reference_resistor_input <= (f == 0);
			thermal_fault <= (f == 1);
			cycles(6);
			check_bit("main_en", 1'b0, main_en);
			check_bit("cam_en", 1'b0, cam_en);
			check_bit("pump_en", 1'b0, pump_en);
			reference_resistor_input <= 1'b0;
			thermal_fault <= 1'b0;
			cycles(6);
			check_bit("main_en back", 1'b1, main_en);
		end
		$display("test fault done");

		// second reset in mid-run; the receiver needs link edges while it is low
		rst_b <= 1'b0;
		host.idle_clocks(4);
		cycles(2);
		rst_b <= 1'b1;
		cycles(4);
		check_bit("shutdown rst", 1'b1, shutdown);
		check_val("main_dac rst", 8'h00, main_dac);
		check_val("pump rst", 8'h00, {6'h00, pump_mode});
		frame(8'h36, 24'h2a_00_00, 3);
		check_val("main_dac after rst", 8'h2a, main_dac);
		$display("test mid reset done");

		frame(8'h36, 24'h00_50_00, 3);
		check_bit("main_en zero", 1'b0, main_en);
		check_bit("cam_en zero", 1'b0, cam_en);
		check_bit("aux_en zero", 1'b0, aux_en);
		check_bit("shutdown part", 1'b0, shutdown);
		frame(8'h36, 24'h00_00_00, 3);
		check_bit("shutdown all", 1'b1, shutdown);
		$display("test zero codes done");
		results();
	end
endmodule : test_led_driver_i2c_mode_control
